//--- rtl/csxe_pkg.sv
package csxe_pkg;

  // opcode field position and width
  localparam int OPC_MSB = 31;
  localparam int OPC_LSB = 26;

  // primary opcodes of the executed instructions
  localparam logic [5:0] OP_SUB   = 6'h32;  // 110010
  localparam logic [5:0] OP_STW   = 6'h16;  // 010110
  localparam logic [5:0] OP_WCSR  = 6'h34;  // 110100
  localparam logic [5:0] OP_XNOR  = 6'h29;  // 101001
  localparam logic [5:0] OP_XNORI = 6'h09;  // 001001
  localparam logic [5:0] OP_XOR   = 6'h26;  // 100110

  // result latency in cycles of each executed instruction
  localparam int RESULT_CYCLES = 1;

  // values after reset
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [4:0]  SEL_RST  = 5'h00;

  // register file write port
  typedef struct packed {
    logic        en;
    logic [4:0]  idx;
    logic [31:0] data;
  } csxe_gpr_wr_t;

  // control/status register write port
  typedef struct packed {
    logic        en;
    logic [4:0]  sel;
    logic [31:0] data;
  } csxe_csr_wr_t;

  // big-endian store: word address plus byte lanes, lane 0 at address
  typedef struct packed {
    logic        en;
    logic [31:0] addr;
    logic [3:0][7:0] lanes;
  } csxe_store_t;

endpackage

//--- rtl/csxe_exec.sv
`timescale 1ns/1ns
module csxe_exec (
  input  wire logic                  REF_CLK,
  input  wire logic                  RST,
  input  wire logic                  INSTR_VALID,
  input  wire logic [31:0]           INSTR,
  input  wire logic [31:0]           OPERAND_Y_VALUE,
  input  wire logic [31:0]           OPERAND_Z_VALUE,
  output logic [4:0]                 OPERAND_Y_IDX,
  output logic [4:0]                 OPERAND_Z_IDX,
  output csxe_pkg::csxe_gpr_wr_t     GPR_WR,
  output csxe_pkg::csxe_csr_wr_t     CSR_WR,
  output csxe_pkg::csxe_store_t      STORE,
  output logic                       ILLEGAL
);

  ////////////////////////////////////////////////////////////////////////////
  // field decode
  logic [5:0]  opcode;
  logic [4:0]  operand_field_y;
  logic [4:0]  operand_field_z;
  logic [4:0]  dest_field;
  logic [15:0] immediate_16bit_field;
  logic        rr_pad_ok;

  // opcode and operand fields sliced out of the instruction word
  assign opcode                = INSTR[csxe_pkg::OPC_MSB:csxe_pkg::OPC_LSB];
  assign operand_field_y       = INSTR[25:21];
  assign operand_field_z       = INSTR[20:16];
  assign dest_field            = INSTR[15:11];
  assign immediate_16bit_field = INSTR[15:0];
  assign rr_pad_ok             = (INSTR[10:0] == 11'h000);

  ////////////////////////////////////////////////////////////////////////////
  // instruction classes
  logic is_sub;
  logic is_xor;
  logic is_xnor;
  logic is_xnori;
  logic store_word_instr;
  logic is_wcsr;
  logic is_rr;
  logic known;

  // register forms need their low eleven bits clear to be accepted
  assign is_sub           = INSTR_VALID && opcode == csxe_pkg::OP_SUB && rr_pad_ok;
  assign is_xor           = INSTR_VALID && opcode == csxe_pkg::OP_XOR && rr_pad_ok;
  assign is_xnor          = INSTR_VALID && opcode == csxe_pkg::OP_XNOR && rr_pad_ok;
  assign is_xnori         = INSTR_VALID && opcode == csxe_pkg::OP_XNORI;
  assign store_word_instr = INSTR_VALID && opcode == csxe_pkg::OP_STW;
  assign is_wcsr          = INSTR_VALID && opcode == csxe_pkg::OP_WCSR;
  assign is_rr            = is_sub || is_xor || is_xnor;
  assign known            = is_rr || is_xnori || store_word_instr || is_wcsr;

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic and logic
  function automatic logic [31:0] zext16(input logic [15:0] v);
    zext16 = {16'h0000, v};
  endfunction

  function automatic logic [31:0] sext16(input logic [15:0] v);
    sext16 = {{16{v[15]}}, v};
  endfunction

  logic [31:0] diff;
  logic [31:0] xor_rr;
  logic [31:0] xnor_rr;
  logic [31:0] xnor_ri;
  logic [31:0] alu_out;
  logic [31:0] st_addr;
  logic [3:0][7:0] st_lanes;

  assign diff     = OPERAND_Y_VALUE - OPERAND_Z_VALUE;
  assign xor_rr   = OPERAND_Y_VALUE ^ OPERAND_Z_VALUE;
  assign xnor_rr  = ~(OPERAND_Y_VALUE ^ OPERAND_Z_VALUE);
  assign xnor_ri  = ~(OPERAND_Y_VALUE ^ zext16(immediate_16bit_field));
  assign alu_out  = is_sub  ? diff :
                    is_xor  ? xor_rr :
                    is_xnor ? xnor_rr : xnor_ri;
  // base is the y operand, data the z operand
  assign st_addr  = OPERAND_Y_VALUE + sext16(immediate_16bit_field);
  // lane 0 lands at the address itself: most significant byte first
  assign st_lanes = {OPERAND_Z_VALUE[7:0], OPERAND_Z_VALUE[15:8],
                     OPERAND_Z_VALUE[23:16], OPERAND_Z_VALUE[31:24]};

  ////////////////////////////////////////////////////////////////////////////
  // next values of the write ports
  csxe_pkg::csxe_gpr_wr_t next_gpr;
  csxe_pkg::csxe_csr_wr_t next_csr;
  csxe_pkg::csxe_store_t  next_store;

  // xnori writes its result to the operand z field
  assign next_gpr.en     = is_rr || is_xnori;
  assign next_gpr.idx    = is_xnori ? operand_field_z : dest_field;
  assign next_gpr.data   = alu_out;
  // the select sits in the y field, the source in the z field
  assign next_csr.en     = is_wcsr;
  assign next_csr.sel    = operand_field_y;
  assign next_csr.data   = OPERAND_Z_VALUE;
  assign next_store.en   = store_word_instr;
  assign next_store.addr = st_addr;
  assign next_store.lanes = st_lanes;

  ////////////////////////////////////////////////////////////////////////////
  // operand fetch indices are registered too, outputs come from flops
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      OPERAND_Y_IDX <= csxe_pkg::SEL_RST;
      OPERAND_Z_IDX <= csxe_pkg::SEL_RST;
    end else begin
      OPERAND_Y_IDX <= operand_field_y;
      OPERAND_Z_IDX <= operand_field_z;
    end
  end

  // one-cycle result: write ports register the decoded outcome
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      GPR_WR  <= '{en: 1'b0, idx: csxe_pkg::SEL_RST, data: csxe_pkg::WORD_RST};
      CSR_WR  <= '{en: 1'b0, sel: csxe_pkg::SEL_RST, data: csxe_pkg::WORD_RST};
      STORE   <= '{en: 1'b0, addr: csxe_pkg::WORD_RST, lanes: csxe_pkg::WORD_RST};
      ILLEGAL <= 1'b0;
    end else begin
      GPR_WR  <= next_gpr;
      CSR_WR  <= next_csr;
      STORE   <= next_store;
      ILLEGAL <= INSTR_VALID && !known;
    end
  end

endmodule

//--- verif/csxe_exec_asserts.sv
`timescale 1ns/1ns
// one-cycle results of each executed instruction
module csxe_exec_asserts (
  input wire logic                   REF_CLK,
  input wire logic                   RST,
  input wire logic                   INSTR_VALID,
  input wire logic [31:0]            INSTR,
  input wire logic [31:0]            OPERAND_Y_VALUE,
  input wire logic [31:0]            OPERAND_Z_VALUE,
  input wire csxe_pkg::csxe_gpr_wr_t GPR_WR,
  input wire csxe_pkg::csxe_csr_wr_t CSR_WR,
  input wire csxe_pkg::csxe_store_t  STORE
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // expected results worked out from the issuing cycle
  wire [31:0] y = OPERAND_Y_VALUE, z = OPERAND_Z_VALUE, dsub = y - z,
    dxn = ~(y ^ z), dxi = ~(y ^ {16'h0, INSTR[15:0]}),
    sa = y + {{16{INSTR[15]}}, INSTR[15:0]},
    zr = {z[7:0], z[15:8], z[23:16], z[31:24]};
  wire [5:0] op = INSTR[31:26];
  wire [4:0] fy = INSTR[25:21], fz = INSTR[20:16], fd = INSTR[15:11];
  wire       v = INSTR_VALID;
  wire       rr = v && INSTR[10:0] == 11'h0;
  a_sub_diff: assert property (rr && op == csxe_pkg::OP_SUB
    |=> GPR_WR.en && GPR_WR.data == $past(dsub)) else $error("sub");
  a_store_addr: assert property (v && op == csxe_pkg::OP_STW
    |=> STORE.en && STORE.addr == $past(sa)) else $error("addr");
  a_store_lanes: assert property (v && op == csxe_pkg::OP_STW
    |=> STORE.lanes == $past(zr)) else $error("lanes");
  a_csr_copy: assert property (v && op == csxe_pkg::OP_WCSR
    |=> CSR_WR.en && CSR_WR.sel == $past(fy) && CSR_WR.data == $past(z))
    else $error("csr");
  a_xnor_reg: assert property (rr && op == csxe_pkg::OP_XNOR
    |=> GPR_WR.data == $past(dxn)) else $error("xnor");
  a_xnor_imm: assert property (v && op == csxe_pkg::OP_XNORI
    |=> GPR_WR.idx == $past(fz) && GPR_WR.data == $past(dxi)) else $error("xnori");
  a_xor_reg: assert property (rr && op == csxe_pkg::OP_XOR
    |=> GPR_WR.en && GPR_WR.data == ~$past(dxn)) else $error("xor");
  a_dest_field: assert property (rr && op == csxe_pkg::OP_XOR
    |=> GPR_WR.idx == $past(fd)) else $error("dest");
  c_gpr: cover property (GPR_WR.en);
  c_csr: cover property (CSR_WR.en);
  c_store: cover property (STORE.en);
endmodule
bind csxe_exec csxe_exec_asserts csxe_exec_asserts_inst (.*);

//--- verif/cpu_sub_xor_store_csr_exec_test.sv
`timescale 1ns/1ns
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin fails++; \
  $display("wrong value %s exp %h got %h", n, e, a); end end
module cpu_sub_xor_store_csr_exec_test;
  logic        REF_CLK = 1'h0, RST = 1'h1, INSTR_VALID = 1'h0, ILLEGAL, el;
  logic [31:0] INSTR = 32'h0, y = 32'h0, z = 32'h0, w;
  wire  [31:0] OPERAND_Y_VALUE = y, OPERAND_Z_VALUE = z;
  logic [4:0]  OPERAND_Y_IDX, OPERAND_Z_IDX;
  csxe_pkg::csxe_gpr_wr_t GPR_WR, eg;
  csxe_pkg::csxe_csr_wr_t CSR_WR, ec;
  csxe_pkg::csxe_store_t  STORE, es;
  int fails, num_checks, cyc, k;
  logic [5:0] ops [6] = '{csxe_pkg::OP_SUB, csxe_pkg::OP_XOR,
    csxe_pkg::OP_XNOR, csxe_pkg::OP_XNORI, csxe_pkg::OP_STW, csxe_pkg::OP_WCSR};
  csxe_exec csxe_exec_inst (.*);
  always #20 REF_CLK = ~REF_CLK;
  // cuts a hang short
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc > 3000) begin
      fails++;
      final_report();
    end
  end
  task automatic final_report();
    if (fails == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // back-to-back random instructions, each checked one cycle later
  initial begin
    void'($urandom(32'ha9a4));
    repeat (20) @(negedge REF_CLK);
    RST = 1'h0;
    for (int i = 0; i < 400; i++) begin
      k = $urandom_range(7);
      y = $urandom;
      z = $urandom;
      w = $urandom;
      if (k < 3 && w[31]) w[10:0] = 11'h0;
      eg = '0;
      ec = '0;
      es = '0;
      el = k == 6 || (k < 3 && w[10:0] != 11'h0);
      INSTR = {k < 6 ? ops[k] : 6'h3f, w[25:0]};
      INSTR_VALID = k != 7;
      case (k)
        0: eg = '{1'h1, w[15:11], y - z};
        1: eg = '{1'h1, w[15:11], y ^ z};
        2: eg = '{1'h1, w[15:11], ~(y ^ z)};
        3: eg = '{1'h1, w[20:16], ~(y ^ {16'h0, w[15:0]})};
        4: es = '{1'h1, y + {{16{w[15]}}, w[15:0]},
             {z[7:0], z[15:8], z[23:16], z[31:24]}};
        5: ec = '{1'h1, w[25:21], z};
        default: ;
      endcase
      if (k < 3 && w[10:0] != 11'h0) eg = '0;
      @(negedge REF_CLK);
      `CHK("gpr", eg, GPR_WR.en ? GPR_WR : '0)
      `CHK("csr", ec, CSR_WR.en ? CSR_WR : '0)
      `CHK("store", es, STORE.en ? STORE : '0)
      `CHK("illegal", el, ILLEGAL)
      `CHK("y_idx", w[25:21], OPERAND_Y_IDX)
      `CHK("z_idx", w[20:16], OPERAND_Z_IDX)
    end
    final_report();
  end
endmodule
